//--- core/scp_dev.sv
// Device end: serial port decoder with its byte register space
`timescale 1ns/100ps
module scp_dev #(
  // Arbitrary identification value
  parameter logic [7:0] CHIP_ID = 8'h5A
)(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Serial link
  scp_if.dev lnk,
  // Applied configuration and port status
  output scp_pkg::scp_cfg_t cfg_act_a,
  output scp_pkg::scp_cfg_t cfg_act_b,
  output logic lsb_first,
  output logic sec_fn_en
);
  typedef enum logic [2:0] {
    SCP_D_IDLE = 3'h1,
    SCP_D_INSTR = 3'h2,
    SCP_D_DATA = 3'h4
  } scp_dst_t;

  typedef struct packed {
    logic [2:0] sclk;
    logic [1:0] csn;
    logic [1:0] sdi;
    scp_dst_t st;
    logic armed;
    logic [15:0] instr;
    logic [3:0] bitcnt;
    logic rd;
    logic [1:0] wlen;
    logic [1:0] left;
    logic [12:0] addr;
    logic [7:0] sh;
    logic sdo;
    logic lsb;
    logic [1:0] chan;
    scp_pkg::scp_cfg_t shd_a;
    scp_pkg::scp_cfg_t shd_b;
    scp_pkg::scp_cfg_t act_a;
    scp_pkg::scp_cfg_t act_b;
  } scp_dstate_t;

  localparam scp_dstate_t D_RST = '{
    csn: 2'h3,
    sdi: 2'h3,
    st: SCP_D_IDLE,
    chan: scp_pkg::CHAN_RST,
    default: '0
  };

  scp_dstate_t q;
  scp_dstate_t d;
  logic rise;
  logic fall;
  logic csn_hi;
  logic wr;
  logic [15:0] ins;
  logic [7:0] shin;

  function automatic logic cfg_hit(input logic [12:0] a);
    cfg_hit = (a >= scp_pkg::A_CFG0) && (a < scp_pkg::A_CFG0 + 13'(scp_pkg::NCFG));
  endfunction

  function automatic logic [1:0] cfg_idx(input logic [12:0] a);
    cfg_idx = 2'(a - scp_pkg::A_CFG0);
  endfunction

  // Readback shows shadow values, not the applied ones
  function automatic logic [7:0] rd_byte(input scp_dstate_t s, input logic [12:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == scp_pkg::A_PORTCFG)
      v = s.lsb ? (scp_pkg::PORTCFG_RST | scp_pkg::PC_LSB_MASK) : scp_pkg::PORTCFG_RST;
    else if (a == scp_pkg::A_CHIPID)
      v = CHIP_ID;
    else if (a == scp_pkg::A_CHANIDX)
      v = {6'h00, s.chan};
    else if (cfg_hit(a))
      v = s.chan[scp_pkg::CH_A] ? s.shd_a[cfg_idx(a)] : s.shd_b[cfg_idx(a)];
    rd_byte = v;
  endfunction

  // Edges seen only after two synchroniser stages
  assign rise = q.sclk[1] && !q.sclk[2];
  assign fall = !q.sclk[1] && q.sclk[2];
  assign csn_hi = q.csn[1];

  always_comb
  begin
    d = q;
    wr = 1'h0;
    ins = {q.instr[14:0], q.sdi[1]};
    shin = q.lsb ? {q.sdi[1], q.sh[7:1]} : {q.sh[6:0], q.sdi[1]};
    d.sclk = {q.sclk[1:0], lnk.sclk};
    d.csn = {q.csn[0], lnk.chip_select_n};
    d.sdi = {q.sdi[0], lnk.sdio};
    case (q.st)
      SCP_D_IDLE:
      begin
        if (csn_hi)
          d.armed = 1'h1;
        else if (q.armed && rise)
        begin
          d.armed = 1'h0;
          d.instr = ins;
          d.bitcnt = 4'h1;
          d.st = SCP_D_INSTR;
        end
      end
      SCP_D_INSTR:
      begin
        // A pause inside the instruction has no byte to resume at
        if (csn_hi)
        begin
          d.st = SCP_D_IDLE;
          d.armed = 1'h1;
        end
        else if (rise)
        begin
          d.instr = ins;
          d.bitcnt = q.bitcnt + 4'h1;
          if (q.bitcnt == scp_pkg::LAST_INSTR_BIT)
          begin
            d.rd = ins[scp_pkg::RW_POS];
            d.wlen = ins[scp_pkg::WL_HI:scp_pkg::WL_LO];
            d.left = ins[scp_pkg::WL_HI:scp_pkg::WL_LO];
            d.addr = ins[scp_pkg::ADDR_W-1:0];
            d.sh = rd_byte(q, ins[scp_pkg::ADDR_W-1:0]);
            d.bitcnt = 4'h0;
            d.st = SCP_D_DATA;
          end
        end
      end
      SCP_D_DATA:
      begin
        if (csn_hi)
        begin
          // Byte-aligned pause keeps position; streaming ends here
          if (q.bitcnt != 4'h0 || q.wlen == scp_pkg::WLEN_STREAM)
          begin
            d.st = SCP_D_IDLE;
            d.armed = 1'h1;
          end
        end
        else if (rise)
        begin
          d.bitcnt = q.bitcnt + 4'h1;
          if (!q.rd)
            d.sh = shin;
          if (q.bitcnt == scp_pkg::LAST_DATA_BIT)
          begin
            wr = !q.rd;
            d.bitcnt = 4'h0;
            d.addr = q.addr + 13'h0001;
            d.sh = rd_byte(q, q.addr + 13'h0001);
            if (q.wlen != scp_pkg::WLEN_STREAM)
            begin
              d.left = q.left - 2'h1;
              if (q.left == 2'h0)
                d.st = SCP_D_IDLE;
            end
          end
        end
        else if (fall && q.rd)
        begin
          d.sdo = q.lsb ? q.sh[0] : q.sh[7];
          d.sh = q.lsb ? {1'h0, q.sh[7:1]} : {q.sh[6:0], 1'h0};
        end
      end
      default:
        d = D_RST;
    endcase

    if (wr)
    begin
      if (q.addr == scp_pkg::A_PORTCFG)
      begin
        // Either mirrored copy of a bit counts, so both orders decode alike
        d.lsb = |(shin & scp_pkg::PC_LSB_MASK);
        if (|(shin & scp_pkg::PC_SRST_MASK))
        begin
          d.lsb = 1'h0;
          d.chan = scp_pkg::CHAN_RST;
          d.shd_a = '0;
          d.shd_b = '0;
        end
      end
      else if (q.addr == scp_pkg::A_CHANIDX)
        d.chan = shin[1:0];
      else if (q.addr == scp_pkg::A_XFER)
      begin
        // Transfer bit is never stored, so it reads back cleared
        if (shin[scp_pkg::XFER_BIT])
        begin
          d.act_a = q.shd_a;
          d.act_b = q.shd_b;
        end
      end
      else if (cfg_hit(q.addr))
      begin
        if (q.chan[scp_pkg::CH_A])
          d.shd_a[cfg_idx(q.addr)] = shin;
        if (q.chan[scp_pkg::CH_B])
          d.shd_b[cfg_idx(q.addr)] = shin;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= D_RST;
    else
      q <= d;
  end

  assign cfg_act_a = q.act_a;
  assign cfg_act_b = q.act_b;
  assign lsb_first = q.lsb;
  assign sec_fn_en = csn_hi && (q.st == SCP_D_IDLE);
  assign lnk.dev_sdo = q.sdo;
  // Drives only in readback with select low
  assign lnk.dev_sdo_oe_n = !((q.st == SCP_D_DATA) && q.rd && !csn_hi);
endmodule

//--- core/scp_pkg.sv
// Constants and types shared by both ends of the serial configuration port
package scp_pkg;
  // What this block does
  // - Serial clock times every access; device never drives it.
  // - Low chip select gates transfers; high is ignored.
  // - Frame starts at first rise after select falls.
  // - Streaming keeps accepting bytes while select stays low.
  // - Select high between bytes pauses, then resumes; in streaming it ends the frame.
  // - Select high: data pin released; secondary functions on only when idle, not during a pause.
  // - Each frame opens with sixteen instruction bits.
  // - Data moves in bytes; count from length bits.
  // - First instruction bit selects read or write.
  // - Read: device drives data pin after instruction.
  // - Data pin input on writes, output on readback.
  // - MSB first after reset; config bit selects LSB.
  // - Host keeps port idle during critical sampling.
  // - Writing transfer bit applies shadows, then self-clears.
  // - Both channels: read returns A, write updates both.

  // Instruction layout, sent in this order
  localparam int INSTR_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int RW_POS = 15;
  localparam int WL_HI = 14;
  localparam int WL_LO = 13;
  localparam int ADDR_W = 13;
  localparam logic [1:0] WLEN_STREAM = 2'h3;
  localparam logic [3:0] LAST_INSTR_BIT = 4'hF;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;

  // Device register space
  localparam logic [12:0] A_PORTCFG = 13'h0000;
  localparam logic [12:0] A_CHIPID = 13'h0001;
  localparam logic [12:0] A_CHANIDX = 13'h0005;
  localparam logic [12:0] A_CFG0 = 13'h0008;
  localparam logic [12:0] A_XFER = 13'h00FF;
  localparam int NCFG = 4;
  localparam logic [7:0] PORTCFG_RST = 8'h18;
  localparam logic [7:0] PC_LSB_MASK = 8'h42;
  localparam logic [7:0] PC_SRST_MASK = 8'h24;
  localparam logic [1:0] CHAN_RST = 2'h3;
  localparam int CH_A = 0;
  localparam int CH_B = 1;
  localparam int XFER_BIT = 0;
  typedef logic [NCFG-1:0][7:0] scp_cfg_t;

  // Host timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int SCLK_PERIOD_NS = 640;
  localparam int GAP_NS = 640;
  localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GAP_CYC = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] HALF_LOAD = 5'(SCLK_HALF_CYC - 1);
  localparam logic [4:0] GAP_LOAD = 5'(GAP_CYC - 1);

  // Host AHB-Lite register offsets and fields
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_ADDR = 8'h04;
  localparam logic [7:0] R_TXD = 8'h08;
  localparam logic [7:0] R_STAT = 8'h0C;
  localparam logic [7:0] R_RXD = 8'h10;
  localparam int C_GO = 0;
  localparam int C_RD = 1;
  localparam int C_WL = 2;
  localparam int C_STALL = 4;
  localparam int C_LSB = 5;
  localparam int C_SCNT = 6;
  localparam int ST_DONE = 1;
endpackage

//--- core/scp_if.sv
// Three-wire serial link joining the host and device ends
`timescale 1ns/100ps
interface scp_if;
  logic sclk;
  logic chip_select_n;
  logic host_sdo;
  logic host_sdo_oe_n;
  logic dev_sdo;
  logic dev_sdo_oe_n;
  logic sdio;

  // Pulled high when neither end drives
  assign sdio = !dev_sdo_oe_n ? dev_sdo : (!host_sdo_oe_n ? host_sdo : 1'h1);

  modport host (output sclk, output chip_select_n, output host_sdo, output host_sdo_oe_n, input sdio);
  modport dev (input sclk, input chip_select_n, input sdio, output dev_sdo, output dev_sdo_oe_n);
endinterface

//--- core/scp_host.sv
// Host end: AHB-Lite registers steering the serial port master
`timescale 1ns/100ps
module scp_host (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Serial link
  scp_if.host lnk
);
  typedef enum logic [4:0] {
    SCP_H_IDLE = 5'h01,
    SCP_H_LOW = 5'h02,
    SCP_H_HIGH = 5'h04,
    SCP_H_TAIL = 5'h08,
    SCP_H_GAP = 5'h10
  } scp_hst_t;

  typedef struct packed {
    scp_hst_t st;
    logic apw;
    logic [7:0] awa;
    logic [31:0] rdq;
    logic rd;
    logic [1:0] wlen;
    logic stall;
    logic lsb;
    logic [1:0] scnt;
    logic [12:0] addr;
    logic [31:0] txd;
    logic [31:0] rxd;
    logic busy;
    logic done;
    logic [4:0] tmr;
    logic [5:0] bidx;
    logic sclk;
    logic csn;
    logic sdo;
    logic [1:0] sdi;
  } scp_hstate_t;

  localparam scp_hstate_t H_RST = '{st: SCP_H_IDLE, csn: 1'h1, default: '0};
  localparam logic [5:0] LAST_INSTR_IDX = 6'(scp_pkg::INSTR_BITS - 1);

  scp_hstate_t q;
  scp_hstate_t d;
  logic aphase;
  logic [2:0] nb;
  logic [5:0] last;
  logic [15:0] instr;

  // Data bit number to word bit, per shift order
  function automatic logic [4:0] bit_pos(input logic [5:0] b, input logic lsb);
    logic [5:0] j;
    j = b - LAST_INSTR_IDX - 6'h01;
    bit_pos = {j[4:3], lsb ? j[2:0] : ~j[2:0]};
  endfunction

  function automatic logic [31:0] reg_rd(input scp_hstate_t s, input logic [7:0] a);
    case (a)
      scp_pkg::R_CTRL: reg_rd = 32'({s.scnt, s.lsb, s.stall, s.wlen, s.rd, 1'h0});
      scp_pkg::R_ADDR: reg_rd = 32'(s.addr);
      scp_pkg::R_TXD: reg_rd = s.txd;
      scp_pkg::R_STAT: reg_rd = 32'({s.done, s.busy});
      scp_pkg::R_RXD: reg_rd = s.rxd;
      default: reg_rd = 32'h0000_0000;
    endcase
  endfunction

  always_comb
  begin
    d = q;
    d.sdi = {q.sdi[0], lnk.sdio};
    nb = (q.wlen == scp_pkg::WLEN_STREAM) ? {1'h0, q.scnt} + 3'h1 : {1'h0, q.wlen} + 3'h1;
    last = 6'(scp_pkg::INSTR_BITS + scp_pkg::BYTE_BITS * int'(nb) - 1);
    instr = {q.rd, q.wlen, q.addr};
    aphase = hsel && hready && htrans[1];
    if (aphase && !hwrite)
      d.rdq = reg_rd(q, haddr[7:0]);
    d.apw = aphase && hwrite;
    if (aphase)
      d.awa = haddr[7:0];
    if (q.apw)
    begin
      if (q.awa == scp_pkg::R_STAT)
      begin
        if (hwdata[scp_pkg::ST_DONE])
          d.done = 1'h0;
      end
      else if (!q.busy)
      begin
        // Set-up registers are frozen while a frame runs
        if (q.awa == scp_pkg::R_ADDR)
          d.addr = hwdata[scp_pkg::ADDR_W-1:0];
        else if (q.awa == scp_pkg::R_TXD)
          d.txd = hwdata;
        else if (q.awa == scp_pkg::R_CTRL)
        begin
          d.rd = hwdata[scp_pkg::C_RD];
          d.wlen = hwdata[scp_pkg::C_WL+1:scp_pkg::C_WL];
          d.stall = hwdata[scp_pkg::C_STALL];
          d.lsb = hwdata[scp_pkg::C_LSB];
          d.scnt = hwdata[scp_pkg::C_SCNT+1:scp_pkg::C_SCNT];
          if (hwdata[scp_pkg::C_GO])
          begin
            d.busy = 1'h1;
            d.csn = 1'h0;
            d.bidx = 6'h00;
            d.rxd = '0;
            d.tmr = scp_pkg::HALF_LOAD;
            d.st = SCP_H_LOW;
          end
        end
      end
    end

    // Frame end set below overrides a clear above
    case (q.st)
      SCP_H_IDLE:
      begin
      end
      SCP_H_LOW:
      begin
        if (q.tmr != 5'h00)
          d.tmr = q.tmr - 5'h01;
        else
        begin
          d.sclk = 1'h1;
          d.tmr = scp_pkg::HALF_LOAD;
          d.st = SCP_H_HIGH;
          if (q.rd && q.bidx > LAST_INSTR_IDX)
            d.rxd[bit_pos(q.bidx, q.lsb)] = q.sdi[1];
        end
      end
      SCP_H_HIGH:
      begin
        if (q.tmr != 5'h00)
          d.tmr = q.tmr - 5'h01;
        else
        begin
          d.sclk = 1'h0;
          d.tmr = scp_pkg::HALF_LOAD;
          if (q.bidx == last)
            d.st = SCP_H_TAIL;
          else
          begin
            d.bidx = q.bidx + 6'h01;
            // A pause would end a streaming frame, so none there
            if (q.stall && q.wlen != scp_pkg::WLEN_STREAM && q.bidx >= LAST_INSTR_IDX && q.bidx[2:0] == 3'h7)
              d.st = SCP_H_TAIL;
            else
              d.st = SCP_H_LOW;
          end
        end
      end
      SCP_H_TAIL:
      begin
        if (q.tmr != 5'h00)
          d.tmr = q.tmr - 5'h01;
        else
        begin
          d.csn = 1'h1;
          if (q.bidx == last)
          begin
            d.busy = 1'h0;
            d.done = 1'h1;
            d.st = SCP_H_IDLE;
          end
          else
          begin
            d.tmr = scp_pkg::GAP_LOAD;
            d.st = SCP_H_GAP;
          end
        end
      end
      SCP_H_GAP:
      begin
        if (q.tmr != 5'h00)
          d.tmr = q.tmr - 5'h01;
        else
        begin
          d.csn = 1'h0;
          d.tmr = scp_pkg::HALF_LOAD;
          d.st = SCP_H_LOW;
        end
      end
      default:
        d = H_RST;
    endcase
    // Instruction always MSB first; order control covers data only
    d.sdo = (q.bidx <= LAST_INSTR_IDX) ? instr[~q.bidx[3:0]] : q.txd[bit_pos(q.bidx, q.lsb)];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= H_RST;
    else
      q <= d;
  end

  assign hreadyout = 1'h1;
  assign hresp = 1'h0;
  assign hrdata = q.rdq;
  assign lnk.sclk = q.sclk;
  assign lnk.chip_select_n = q.csn;
  assign lnk.host_sdo = q.sdo;
  // Held one cycle past the last instruction rise, else the device would sample the pull-up
  assign lnk.host_sdo_oe_n = !(!q.csn && (!q.rd || q.bidx < LAST_INSTR_IDX
    || (q.bidx == LAST_INSTR_IDX && (q.st == SCP_H_LOW || q.tmr == scp_pkg::HALF_LOAD))));
endmodule

//--- verif/scp_chk.sv
// Link checks between the host and device ends
`timescale 1ns/100ps
module scp_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Serial link
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic host_sdo,
  input wire logic host_sdo_oe_n,
  input wire logic dev_sdo,
  input wire logic dev_sdo_oe_n,
  input wire logic sdio
);
  logic sclk_q;
  logic csn_q;
  logic [7:0] rise_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Rises since select last fell
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_q <= 1'h0;
      csn_q <= 1'h1;
      rise_q <= 8'h00;
    end
    else
    begin
      sclk_q <= sclk;
      csn_q <= chip_select_n;
      if (csn_q && !chip_select_n)
        rise_q <= 8'h00;
      else if (sclk && !sclk_q)
        rise_q <= rise_q + 8'h01;
    end
  end

  property p_sclk_hi;
    $rose(sclk) |=> sclk[*7];
  endproperty
  a_sclk_hi: assert property (p_sclk_hi) else $error("sclk high short");
  property p_sclk_lo;
    $fell(sclk) |=> !sclk[*7];
  endproperty
  a_sclk_lo: assert property (p_sclk_lo) else $error("sclk low short");
  property p_sclk_idle;
    $changed(sclk) |-> !chip_select_n;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moved unselected");
  property p_cs_open;
    $fell(chip_select_n) |-> !sclk[*8];
  endproperty
  a_cs_open: assert property (p_cs_open) else $error("frame opened early");
  property p_cs_stall;
    $rose(chip_select_n) |-> chip_select_n[*4];
  endproperty
  a_cs_stall: assert property (p_cs_stall) else $error("select high too short");
  property p_no_fight;
    !(!dev_sdo_oe_n && !host_sdo_oe_n);
  endproperty
  a_no_fight: assert property (p_no_fight) else $error("both ends drive");
  property p_dev_quiet;
    chip_select_n[*6] |-> dev_sdo_oe_n;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drives unselected");
  property p_frame_len;
    $rose(chip_select_n) |-> rise_q[2:0] == 3'h0;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("partial byte");
  property p_host_hold;
    sclk && sclk_q && !host_sdo_oe_n |-> $stable(host_sdo);
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("host bit moved");
  property p_dev_hold;
    sclk && sclk_q && !dev_sdo_oe_n && !$past(dev_sdo_oe_n) |-> $stable(dev_sdo);
  endproperty
  a_dev_hold: assert property (p_dev_hold) else $error("device bit moved");
  property p_dev_turn;
    $fell(dev_sdo_oe_n) |-> rise_q == 8'h10 || rise_q == 8'h00;
  endproperty
  a_dev_turn: assert property (p_dev_turn) else $error("turnaround misplaced");
endmodule

//--- verif/tb_top.sv
// Bench: host end over AHB-Lite talking to the device end
`timescale 1ns/100ps
module tb_top;
  // Arbitrary identification value
  localparam logic [7:0] ID = 8'hC3;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  scp_pkg::scp_cfg_t cfg_a;
  scp_pkg::scp_cfg_t cfg_b;
  logic lsb_first;
  logic sec_fn_en;
  logic [63:0] mon;
  int mon_n;
  int error_cnt;
  int n_compared;

  scp_if lnk();
  scp_host i_scp_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .lnk(lnk.host));
  scp_dev #(.CHIP_ID(ID)) i_scp_dev (.hclk(hclk), .hresetn(hresetn), .lnk(lnk.dev), .cfg_act_a(cfg_a),
    .cfg_act_b(cfg_b), .lsb_first(lsb_first), .sec_fn_en(sec_fn_en));
  scp_chk i_scp_chk (.hclk(hclk), .hresetn(hresetn), .sclk(lnk.sclk), .chip_select_n(lnk.chip_select_n),
    .host_sdo(lnk.host_sdo), .host_sdo_oe_n(lnk.host_sdo_oe_n), .dev_sdo(lnk.dev_sdo),
    .dev_sdo_oe_n(lnk.dev_sdo_oe_n), .sdio(lnk.sdio));

  // Wire bits as seen at each rise
  always @(posedge lnk.sclk)
  begin
    if (lnk.chip_select_n === 1'b0)
    begin
      mon = {mon[62:0], lnk.sdio};
      mon_n++;
    end
  end

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      rev8[i] = b[7 - i];
  endfunction

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'h1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // One frame; d is write data or expected readback, byte 0 first
  task automatic xfer(input logic [7:0] c, input logic [12:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic [31:0] m;
    logic [63:0] e;
    int n;
    n = (c[3:2] == 2'h3) ? int'(c[7:6]) + 1 : int'(c[3:2]) + 1;
    m = (n == 4) ? 32'hFFFF_FFFF : (32'h1 << (8 * n)) - 32'h1;
    e = {48'h0, c[1], c[3:2], a};
    mon_n = 0;
    ahb(1'h1, scp_pkg::R_ADDR, {19'h0, a}, r);
    ahb(1'h1, scp_pkg::R_TXD, d, r);
    ahb(1'h1, scp_pkg::R_CTRL, {24'h0, c | 8'h01}, r);
    r = 32'h0;
    for (int i = 0; i < 4000 && r[scp_pkg::ST_DONE] !== 1'b1; i++)
      ahb(1'h0, scp_pkg::R_STAT, 32'h0, r);
    chk("done", 64'(r[scp_pkg::ST_DONE]), 64'h1);
    chk("hresp", 64'(hresp), 64'h0);
    ahb(1'h1, scp_pkg::R_STAT, 32'h2, r);
    for (int k = 0; k < n; k++)
      e = {e[55:0], c[5] ? rev8(d[8 * k +: 8]) : d[8 * k +: 8]};
    chk("frame bits", mon & ((64'h1 << (16 + 8 * n)) - 64'h1), e);
    chk("frame length", 64'(mon_n), 64'(16 + 8 * n));
    if (c[1])
    begin
      ahb(1'h0, scp_pkg::R_RXD, 32'h0, r);
      chk("read data", 64'(r & m), 64'(d & m));
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end

  // Roughly ten times the expected run
  initial
  begin
    repeat (90000) @(posedge hclk);
    error_cnt++;
    test_done();
  end

  initial
  begin
    hresetn = 1'h0;
    hsel = 1'h0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    mon = 64'h0;
    mon_n = 0;
    error_cnt = 0;
    n_compared = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (4) @(posedge hclk);
    chk("lsb_first", 64'(lsb_first), 64'h0);
    chk("sec_fn_en", 64'(sec_fn_en), 64'h1);
    chk("cfg_a", 64'(cfg_a), 64'h0);
    xfer(8'h06, scp_pkg::A_PORTCFG, {16'h0, ID, scp_pkg::PORTCFG_RST});
    $display("test reset values done");
    xfer(8'h08, scp_pkg::A_CFG0, 32'h0033_2211);
    chk("cfg_a held", 64'(cfg_a), 64'h0);
    xfer(8'h00, scp_pkg::A_XFER, 32'h1);
    chk("cfg_a", 64'(cfg_a), 64'h0033_2211);
    chk("cfg_b", 64'(cfg_b), 64'h0033_2211);
    xfer(8'h02, scp_pkg::A_XFER, 32'h0);
    $display("test transfer done");
    xfer(8'h00, scp_pkg::A_CHANIDX, 32'h2);
    xfer(8'h00, scp_pkg::A_CFG0, 32'h77);
    xfer(8'h00, scp_pkg::A_XFER, 32'h1);
    chk("cfg_b only", 64'(cfg_b), 64'h0033_2277);
    chk("cfg_a kept", 64'(cfg_a), 64'h0033_2211);
    xfer(8'h00, scp_pkg::A_CHANIDX, 32'h3);
    xfer(8'h1A, scp_pkg::A_CFG0, 32'h0033_2211);
    $display("test channels and pause done");
    xfer(8'hCC, scp_pkg::A_CFG0, 32'h8877_6655);
    xfer(8'hCE, scp_pkg::A_CFG0, 32'h8877_6655);
    xfer(8'h00, scp_pkg::A_XFER, 32'h1);
    chk("cfg_a stream", 64'(cfg_a), 64'h8877_6655);
    $display("test streaming done");
    xfer(8'h00, scp_pkg::A_PORTCFG, 32'h42);
    chk("lsb_first set", 64'(lsb_first), 64'h1);
    xfer(8'h20, scp_pkg::A_CFG0, 32'h96);
    xfer(8'h22, scp_pkg::A_CFG0, 32'h96);
    xfer(8'h22, scp_pkg::A_PORTCFG, 32'h5A);
    xfer(8'h20, scp_pkg::A_PORTCFG, 32'h24);
    chk("lsb_first clear", 64'(lsb_first), 64'h0);
    xfer(8'h02, scp_pkg::A_PORTCFG, 32'h18);
    xfer(8'h02, scp_pkg::A_CFG0, 32'h0);
    chk("sec_fn_en idle", 64'(sec_fn_en), 64'h1);
    $display("test bit order done");
    test_done();
  end
endmodule
